/* rtl/lft_pkg.sv */
package lft_pkg;
   // ========================================
   // Field widths and reset values
   // ========================================
   localparam int FRM_W = 4;
   localparam int DUTY_W = 3;
   localparam int DSP_W = 2;
   localparam int CONTRAST_W = 5;
   localparam int NLINE_W = 3;
   localparam int RAM_BYTES = 96;
   localparam int RAM_AW = 7;
   localparam int COM_N = 8;
   localparam int SHARED_N = 4;
   localparam int SEG_N = 48;
   localparam logic [3:0] PHASE_DIV = 4'hF;   // 16 drive ticks per step
   localparam logic [FRM_W-1:0] FRM_RST = 4'h0;
   localparam logic [DUTY_W-1:0] DUTY_RST = 3'h0;
   localparam logic [DUTY_W-1:0] DUTY_SHARED_COM = 3'h4;
   localparam logic [DSP_W-1:0] DSP_OFF = 2'h0;
   localparam logic [DSP_W-1:0] DSP_NORMAL = 2'h1;
   localparam logic [DSP_W-1:0] DSP_ALL_ON = 2'h2;
   localparam logic [DSP_W-1:0] DSP_ALL_OFF = 2'h3;
   // Drive-clock frequency in Hz and core clock in Hz; enable every N.
   localparam int DRIVE_HZ = 32768;
   localparam int CORE_HZ = 10000000;
   localparam int DRIVE_DIV = CORE_HZ / DRIVE_HZ;
endpackage

/* rtl/lft_ram_if.sv */
`timescale 1ns/1ps
interface lft_ram_if;
   logic                         wr_en;
   logic [lft_pkg::RAM_AW-1:0]   wr_addr;
   logic [7:0]                   wr_data;
   logic [lft_pkg::RAM_AW-1:0]   rd_addr;
   logic [7:0]                   rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface

/* rtl/lft_ram.sv */
`timescale 1ns/1ps
module lft_ram #(
   parameter int DEPTH = lft_pkg::RAM_BYTES
) (
   input  wire logic CLK_IN,
   lft_ram_if.mem    bus
);
   logic [7:0] mem [DEPTH];
   logic [7:0] rd_q;

   // ========================================
   // Display data storage, registered read
   // ========================================
   always_ff @(posedge CLK_IN) begin
      if (bus.wr_en && (int'(bus.wr_addr) < DEPTH)) begin
         mem[bus.wr_addr] <= bus.wr_data;
      end
      rd_q <= (int'(bus.rd_addr) < DEPTH) ? mem[bus.rd_addr] : 8'h00;
   end
   assign bus.rd_data = rd_q;
endmodule

/* rtl/lft_frame_timing.sv */
`timescale 1ns/1ps
module lft_frame_timing #(
   parameter int FRM_W  = lft_pkg::FRM_W,
   parameter int DUTY_W = lft_pkg::DUTY_W,
   parameter int SEG_N  = lft_pkg::SEG_N,
   parameter int COM_N  = lft_pkg::COM_N
) (
   input  wire logic                          CLK_IN,
   input  wire logic                          RST_IN,
   input  wire logic                          ENABLE_IN,
   input  wire logic                          CPU_HALT_IN,
   input  wire logic                          DEBUG_RUN_ENABLE_IN,
   input  wire logic                          PIN_DISCHARGE_ENABLE_IN,
   input  wire logic [FRM_W-1:0]              FRAME_COUNT_SELECT_IN,
   input  wire logic [DUTY_W-1:0]             DRIVE_DUTY_SELECT_IN,
   input  wire logic [lft_pkg::DSP_W-1:0]     DISPLAY_STATE_SELECT_IN,
   input  wire logic                          INVERT_IN,
   input  wire logic                          SEG_REVERSE_IN,
   input  wire logic                          COM_REVERSE_IN,
   input  wire logic                          PARTIAL_IN,
   input  wire logic [lft_pkg::NLINE_W-1:0]   NLINE_IN,
   input  wire logic [lft_pkg::CONTRAST_W-1:0] CONTRAST_IN,
   input  wire logic                          RAM_WR_IN,
   input  wire logic [lft_pkg::RAM_AW-1:0]    RAM_ADDR_IN,
   input  wire logic [7:0]                    RAM_DATA_IN,
   output logic [COM_N-1:0]                   COM_OUT,
   output logic [COM_N-1:0]                   COM_OE_OUT,
   output logic [SEG_N-1:0]                   SEG_OUT,
   output logic [SEG_N-1:0]                   SEG_OE_OUT,
   output logic                               FRAME_MONITOR_OUT,
   output logic                               FRAME_IRQ_OUT,
   output logic [lft_pkg::CONTRAST_W-1:0]     CONTRAST_OUT,
   output logic                               DRIVE_ACTIVE_OUT
);
   localparam int DIV_W = $clog2(lft_pkg::DRIVE_DIV + 1);

   lft_ram_if ram_bus ();

   // ========================================
   // Drive clock enable and debug gating
   // ========================================
   logic [DIV_W-1:0] div_cnt;
   logic [DIV_W-1:0] next_div_cnt;
   logic             tick;
   logic             clk_gated;

   // Halting only masks the enable, so every setting input is untouched.
   assign clk_gated = ENABLE_IN &&
                      !(CPU_HALT_IN && !DEBUG_RUN_ENABLE_IN);

   always_comb begin
      next_div_cnt = div_cnt;
      tick = 1'b0;
      if (clk_gated) begin
         if (div_cnt == DIV_W'(lft_pkg::DRIVE_DIV - 1)) begin
            next_div_cnt = '0;
            tick = 1'b1;
         end else begin
            next_div_cnt = div_cnt + DIV_W'(1);
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // ========================================
   // Frame sequencer
   // ========================================
   logic [3:0]        sub_cnt;
   logic [FRM_W-1:0]  frm_cnt;
   logic [DUTY_W-1:0] com_idx;
   logic [FRM_W-1:0]  frm_lat;
   logic [DUTY_W-1:0] duty_lat;
   logic              frame_sig;
   logic              irq;
   logic [3:0]        next_sub_cnt;
   logic [FRM_W-1:0]  next_frm_cnt;
   logic [DUTY_W-1:0] next_com_idx;
   logic [FRM_W-1:0]  next_frm_lat;
   logic [DUTY_W-1:0] next_duty_lat;
   logic              next_frame_sig;
   logic              next_irq;
   logic              frame_end;

   always_comb begin
      next_sub_cnt = sub_cnt;
      next_frm_cnt = frm_cnt;
      next_com_idx = com_idx;
      next_frm_lat = frm_lat;
      next_duty_lat = duty_lat;
      next_frame_sig = frame_sig;
      next_irq = 1'b0;
      frame_end = 1'b0;
      if (tick) begin
         next_sub_cnt = sub_cnt + 4'h1;
         if (sub_cnt == lft_pkg::PHASE_DIV) begin
            next_sub_cnt = 4'h0;
            next_frm_cnt = frm_cnt + FRM_W'(1);
            if (frm_cnt == frm_lat) begin
               next_frm_cnt = '0;
               next_com_idx = com_idx + DUTY_W'(1);
               if (com_idx == duty_lat) begin
                  next_com_idx = '0;
                  frame_end = 1'b1;
               end
            end
         end
      end
      if (frame_end) begin
         // New frame count and duty settings only take hold here, never mid-frame.
         next_frm_lat = FRAME_COUNT_SELECT_IN;
         next_duty_lat = DRIVE_DUTY_SELECT_IN;
         next_frame_sig = !frame_sig;
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sub_cnt <= 4'h0;
         frm_cnt <= '0;
         com_idx <= '0;
         frm_lat <= lft_pkg::FRM_RST;
         duty_lat <= lft_pkg::DUTY_RST;
         frame_sig <= 1'b0;
         irq <= 1'b0;
      end else begin
         sub_cnt <= next_sub_cnt;
         frm_cnt <= next_frm_cnt;
         com_idx <= next_com_idx;
         frm_lat <= next_frm_lat;
         duty_lat <= next_duty_lat;
         frame_sig <= next_frame_sig;
         irq <= next_irq;
      end
   end

   assign FRAME_MONITOR_OUT = frame_sig;
   assign FRAME_IRQ_OUT = irq;

   // ========================================
   // Display memory
   // ========================================
   logic [lft_pkg::RAM_AW-1:0] rd_addr;

   assign ram_bus.wr_en = RAM_WR_IN;
   assign ram_bus.wr_addr = RAM_ADDR_IN;
   assign ram_bus.wr_data = RAM_DATA_IN;
   // One byte per segment, bit per common; byte index is the segment number.
   assign ram_bus.rd_addr = rd_addr;

   lft_ram u_ram (
      .CLK_IN (CLK_IN),
      .bus    (ram_bus)
   );

   // ========================================
   // Segment scan: one column read per enabled clock
   // ========================================
   logic [5:0]       scan_seg;
   logic [5:0]       next_scan_seg;
   logic [5:0]       lat_seg;
   logic [SEG_N-1:0] seg_pat;
   logic [SEG_N-1:0] next_seg_pat;
   logic [DUTY_W-1:0] com_phys;

   assign com_phys = COM_REVERSE_IN ? DUTY_W'(duty_lat - com_idx)
                                    : com_idx;
   assign rd_addr = lft_pkg::RAM_AW'(scan_seg);

   always_comb begin
      next_scan_seg = scan_seg;
      next_seg_pat = seg_pat;
      if (clk_gated) begin
         next_scan_seg = (scan_seg == 6'(SEG_N - 1)) ? 6'h00
                                                    : scan_seg + 6'h01;
         next_seg_pat[lat_seg] = ram_bus.rd_data[com_phys];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         scan_seg <= 6'h00;
         lat_seg <= 6'h00;
         seg_pat <= '0;
      end else begin
         scan_seg <= next_scan_seg;
         lat_seg <= scan_seg;
         seg_pat <= next_seg_pat;
      end
   end

   // ========================================
   // Waveform and pin drive
   // ========================================
   logic [COM_N-1:0] com_next_out;
   logic [COM_N-1:0] com_next_oe;
   logic [SEG_N-1:0] seg_next_out;
   logic [SEG_N-1:0] seg_next_oe;
   logic             ac_phase;
   logic             shared_com;
   logic             running;
   logic [SEG_N-1:0] pat_eff;
   logic [SEG_N-1:0] pat_rev;
   logic [COM_N-1:0] com_q;
   logic [COM_N-1:0] com_oe_q;
   logic [SEG_N-1:0] seg_q;
   logic [SEG_N-1:0] seg_oe_q;

   assign running = clk_gated && DISPLAY_STATE_SELECT_IN != lft_pkg::DSP_OFF;
   assign shared_com = duty_lat >= lft_pkg::DUTY_SHARED_COM;
   assign ac_phase = frame_sig ^ (NLINE_IN != '0 &&
                     com_idx[0] && NLINE_IN[0]);

   genvar gi;
   generate
      for (gi = 0; gi < SEG_N; gi++) begin : g_rev
         assign pat_rev[gi] = seg_pat[SEG_N - 1 - gi];
      end
   endgenerate

   always_comb begin
      pat_eff = SEG_REVERSE_IN ? pat_rev : seg_pat;
      case (DISPLAY_STATE_SELECT_IN)
         lft_pkg::DSP_ALL_ON: pat_eff = '1;
         lft_pkg::DSP_ALL_OFF: pat_eff = '0;
         default: pat_eff = INVERT_IN ? pat_eff : ~pat_eff;
      endcase
      com_next_out = '0;
      com_next_oe = '0;
      seg_next_out = '0;
      seg_next_oe = '0;
      if (running) begin
         for (int i = 0; i < COM_N; i++) begin
            if (i <= int'(duty_lat) && !(PARTIAL_IN && i >= COM_N / 2)) begin
               com_next_oe[i] = 1'b1;
               com_next_out[i] = (DISPLAY_STATE_SELECT_IN ==
                                  lft_pkg::DSP_ALL_OFF)
                                 ? ac_phase
                                 : ((i == int'(com_idx)) ^ ac_phase);
            end
         end
         seg_next_oe = '1;
         seg_next_out = pat_eff ^ {SEG_N{ac_phase}};
         if (shared_com) begin
            seg_next_oe[lft_pkg::SHARED_N-1:0] = '0;
         end else begin
            com_next_oe[COM_N-1:lft_pkg::SHARED_N] = '0;
         end
      end else if (PIN_DISCHARGE_ENABLE_IN) begin
         com_next_oe = '1;
         seg_next_oe = '1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         com_q <= '0;
         com_oe_q <= '0;
         seg_q <= '0;
         seg_oe_q <= '0;
      end else begin
         com_q <= com_next_out;
         com_oe_q <= com_next_oe;
         seg_q <= seg_next_out;
         seg_oe_q <= seg_next_oe;
      end
   end

   assign COM_OUT = com_q;
   assign COM_OE_OUT = com_oe_q;
   assign SEG_OUT = seg_q;
   assign SEG_OE_OUT = seg_oe_q;
   assign CONTRAST_OUT = CONTRAST_IN;
   assign DRIVE_ACTIVE_OUT = clk_gated;

   // ========================================
   // Checks
   // ========================================
   halt_stops_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (ENABLE_IN && CPU_HALT_IN && !DEBUG_RUN_ENABLE_IN) |-> !tick)
      else $error("Drive tick while halted.");
   run_keeps_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (ENABLE_IN && DEBUG_RUN_ENABLE_IN) |-> clk_gated)
      else $error("Clock withheld with debug run on.");
   dark_stop_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !clk_gated |=> (COM_OUT == '0 && SEG_OUT == '0 &&
      (COM_OE_OUT == '0 || $past(PIN_DISCHARGE_ENABLE_IN))))
      else $error("Pins driven while clock stopped.");
   discharge_low_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (!running && PIN_DISCHARGE_ENABLE_IN) |=>
      (SEG_OE_OUT == '1 && SEG_OUT == '0))
      else $error("Discharge did not drive low.");
   irq_frame_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $changed(frame_sig) |-> irq)
      else $error("Frame without interrupt.");
   mon_mirror_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      irq |-> FRAME_MONITOR_OUT != $past(FRAME_MONITOR_OUT))
      else $error("Monitor did not toggle at frame.");
   latch_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !frame_end |=> $stable(duty_lat) && $stable(frm_lat))
      else $error("Setting changed mid-frame.");
   step_len_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (tick && sub_cnt == 4'hF) |=> sub_cnt == 4'h0)
      else $error("Step not sixteen ticks.");
   shared_pin_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (running && !shared_com) |=> COM_OE_OUT[7:4] == 4'h0)
      else $error("Shared pins driven as commons.");
endmodule

/* testbench/lft_panel.sv */
`timescale 1ns/1ps
// ========================================
// Passive glass panel seen from the pins
// ========================================
module lft_panel (
   input  wire logic        clk_in,
   input  wire logic [7:0]  com_in,
   input  wire logic [7:0]  com_oe_in,
   input  wire logic [47:0] seg_in,
   input  wire logic [47:0] seg_oe_in,
   output logic [55:0]      level_out
);
   logic        flip = 1'b0;
   logic [55:0] drv;
   logic [55:0] oe;

   always_ff @(posedge clk_in) begin
      flip <= ~flip;
   end

   assign drv = {seg_in, com_in};
   assign oe  = {seg_oe_in, com_oe_in};

   // A floating electrode has no defined level, so an undriven pin shows
   // a pattern that changes every cycle, opposite on neighbouring pins, so no two adjacent pins pass for low together.
   always_comb begin
      for (int i = 0; i < 56; i++) begin
         level_out[i] = oe[i] ? drv[i] : (flip ^ i[0]);
      end
   end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        clk;
   logic        rst;
   logic        en;
   logic        halt;
   logic        debug_run_enable;
   logic        dis;
   logic        ram_wr;
   logic [3:0]  frm;
   logic [2:0]  duty;
   logic [1:0]  dsp;
   logic [4:0]  con;
   logic [6:0]  ram_addr;
   logic [7:0]  ram_data;
   logic [7:0]  com;
   logic [7:0]  com_oe;
   logic [47:0] seg;
   logic [47:0] seg_oe;
   logic        mon;
   logic        irq;
   logic        act;
   logic [4:0]  con_o;
   logic [55:0] lvl;
   logic        last_mon;
   logic        inv;
   logic        srev;
   logic        crev;
   logic        part;
   logic [2:0]  nline;
   int          errors;
   int          samples_checked;
   int          cyc;
   int          prev;
   int          d;
   int          n;

   lft_frame_timing uut (
      .CLK_IN(clk), .RST_IN(rst), .ENABLE_IN(en), .CPU_HALT_IN(halt),
      .DEBUG_RUN_ENABLE_IN(debug_run_enable), .PIN_DISCHARGE_ENABLE_IN(dis),
      .FRAME_COUNT_SELECT_IN(frm), .DRIVE_DUTY_SELECT_IN(duty),
      .DISPLAY_STATE_SELECT_IN(dsp), .INVERT_IN(inv),
      .SEG_REVERSE_IN(srev), .COM_REVERSE_IN(crev), .PARTIAL_IN(part),
      .NLINE_IN(nline), .CONTRAST_IN(con), .RAM_WR_IN(ram_wr),
      .RAM_ADDR_IN(ram_addr), .RAM_DATA_IN(ram_data), .COM_OUT(com),
      .COM_OE_OUT(com_oe), .SEG_OUT(seg), .SEG_OE_OUT(seg_oe),
      .FRAME_MONITOR_OUT(mon), .FRAME_IRQ_OUT(irq),
      .CONTRAST_OUT(con_o), .DRIVE_ACTIVE_OUT(act)
   );

   lft_panel panel (
      .clk_in(clk), .com_in(com), .com_oe_in(com_oe), .seg_in(seg),
      .seg_oe_in(seg_oe), .level_out(lvl)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ========================================
   // Shared tasks
   // ========================================
   function automatic int fr(input int f, input int du);
      return 16 * (f + 1) * (du + 1) * lft_pkg::DRIVE_DIV;
   endfunction

   task automatic go(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                      input string msg);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s: seen %0h expected %0h", $time, msg, seen,
                  exp);
      end
   endtask

   // Returns the span since the previous frame pulse.
   task automatic frame(output int span);
      int k;
      k = 0;
      @(negedge clk);
      while (irq !== 1'b1 && k < 30000) begin
         @(negedge clk);
         k++;
      end
      if (irq !== 1'b1) begin
         errors++;
         $display("[ERR] %0t frame pulse missing", $time);
      end
      chk(mon, !last_mon, "monitor toggle");
      last_mon = mon;
      span = cyc - prev;
      prev = cyc;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The longest path is about 78000 cycles; this leaves some margin.
   initial begin
      #10_000_000;
      errors++;
      summarize();
   end

   // ========================================
   // Tests
   // ========================================
   initial begin
      errors = 0;
      samples_checked = 0;
      cyc = 0;
      prev = 0;
      last_mon = 1'b0;
      rst = 1'b1;
      en = 1'b1;
      halt = 1'b0;
      debug_run_enable = 1'b0;
      dis = 1'b0;
      frm = 4'h0;
      duty = 3'h0;
      dsp = lft_pkg::DSP_OFF;
      con = 5'h00;
      ram_wr = 1'b0;
      ram_addr = 7'h00;
      ram_data = 8'h00;
      inv = 1'b1;
      srev = 1'b0;
      crev = 1'b0;
      part = 1'b0;
      nline = 3'h0;
      go(20);
      rst = 1'b0;
      go(1);
      chk(mon, 1'b0, "monitor idle level");
      // The last write lies beyond the memory and must be ignored.
      for (int i = 0; i <= 96; i++) begin
         ram_wr = 1'b1;
         ram_addr = i[6:0];
         ram_data = i[7:0] ^ 8'hA5;
         go(1);
      end
      ram_wr = 1'b0;
      for (int i = 0; i < 32; i++) begin
         con = i[4:0];
         #1 chk(con_o, i[4:0], "contrast level");
      end
      dis = 1'b1;
      go(2);
      chk(com_oe[3:0], 4'hF, "discharge enable");
      chk(lvl[3:0], 4'h0, "discharge level");
      chk(|(seg & seg_oe), 1'b0, "segment low");
      dis = 1'b0;
      go(2);
      chk({com_oe, seg_oe}, 56'h0, "pins released");
      dis = 1'b1;
      dsp = lft_pkg::DSP_NORMAL;
      $display("test pins done");

      frame(d);
      frame(d);
      chk(d, fr(0, 0), "static frame length");
      $display("test frame length done");

      go(1);
      halt = 1'b1;
      #1 chk(act, 1'b0, "clock withheld in halt");
      n = 0;
      repeat (5000) begin
         @(negedge clk);
         if (irq === 1'b1) n++;
      end
      chk(n, 0, "frames during halt");
      chk({com, seg}, 56'h0, "display dark in halt");
      halt = 1'b0;
      #1 chk(act, 1'b1, "clock resumed");
      frame(d);
      frame(d);
      chk(d, fr(0, 0), "settings kept over halt");
      go(1);
      debug_run_enable = 1'b1;
      halt = 1'b1;
      #1 chk(act, 1'b1, "clock kept in halt");
      frame(d);
      chk(d, fr(0, 0), "frames in debug run");
      halt = 1'b0;
      debug_run_enable = 1'b0;
      $display("test halt done");

      // Static duty keeps common 0 selected, so bit 0 of each byte shows.
      go(2);
      chk(seg ^ {48{mon}}, 48'h5555_5555_5555, "display data");
      chk(com[0] ^ mon, 1'b1, "selected common");
      srev = 1'b1;
      go(2);
      chk(seg ^ {48{mon}}, 48'hAAAA_AAAA_AAAA, "segments reversed");
      srev = 1'b0;
      inv = 1'b0;
      go(2);
      chk(seg ^ {48{mon}}, 48'hAAAA_AAAA_AAAA, "inverted image");
      inv = 1'b1;
      dsp = lft_pkg::DSP_ALL_ON;
      go(2);
      chk(seg ^ {48{mon}}, 48'hFFFF_FFFF_FFFF, "all on");
      dsp = lft_pkg::DSP_ALL_OFF;
      go(2);
      chk({com[0], seg} ^ {49{mon}}, 49'h0, "all off static");
      dsp = lft_pkg::DSP_NORMAL;
      $display("test display modes done");

      go(50);
      frm = 4'h1;
      frame(d);
      chk(d, fr(0, 0), "old count kept to frame end");
      frame(d);
      chk(d, fr(1, 0), "count frame length");
      go(50);
      frm = 4'h0;
      duty = 3'h4;
      frame(d);
      chk(d, fr(1, 0), "old duty kept to frame end");
      go(2);
      chk({com_oe[7:4], seg_oe[3:0]}, 8'h10, "shared pins as commons");
      part = 1'b1;
      go(2);
      chk(com_oe, 8'h0F, "partial commons");
      part = 1'b0;
      crev = 1'b1;
      go(60);
      chk(seg ^ {48{mon}}, 48'h0000_FFFF_0000, "commons reversed");
      crev = 1'b0;
      // Wait into the second common step of this five-common frame.
      go(4900);
      nline = 3'h1;
      go(2);
      chk(seg ^ {48{mon}}, 48'h3333_3333_3333, "line inversion");
      nline = 3'h0;
      duty = 3'h3;
      frame(d);
      chk(d, fr(0, 4), "duty frame length");
      go(2);
      chk({com_oe[7:4], seg_oe[3:0]}, 8'h0F, "shared pins as segments");
      $display("test duty done");
      summarize();
   end
endmodule
